// >>> llp_top.sv
`timescale 1ns/1ns
`default_nettype none
module llp_top
  import llp_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // reference and mode pins
  input  wire logic              hsync_in,
  input  wire logic              div_sel,
  input  wire logic [2:0]        prog_sel,
  input  wire logic [1:0]        hold_mode,
  // divider pin, two-way
  input  wire logic              ext_div_in,
  output logic                   ext_div_out,
  output logic                   ext_div_oe_n,
  // charge pump and lock indicator
  output logic                   pump_src,
  output logic                   pump_snk,
  output logic                   lock_indicator
);
  typedef struct packed {
    llp_mode_e          mode;     // decoded hold mode
    llp_pfd_e           pfd;      // phase detector state
    logic [CNT_W-1:0]   cnt;      // cycles since first edge
    logic [ERR_W-1:0]   err;      // last nonzero signed phase error
    logic               locked;   // last compare was in tolerance
    logic               src;      // charge pump source enable
    logic               snk;      // charge pump sink enable
    logic               lind;     // lock indicator level
    logic               ext_prev; // last sample of divider pin
    logic               oe_n;     // divider pin enable, low drives
    logic [N_W-1:0]     n_val;    // divisor in use
    logic               realign;  // divider realign request
    logic [TOL_W-1:0]   tol;      // lock tolerance in cycles
    logic [THR_W-1:0]   thr;      // fast lock error threshold
    logic [DATA_W-1:0]  rdata;    // apb read data
    logic               rdy;      // apb ready
    logic               err_bus;  // apb slave error
  } llp_top_s;

  localparam llp_top_s RST_S = '{
    mode: LLP_COAST, pfd: PFD_IDLE, cnt: '0, err: '0, locked: 1'b0,
    src: 1'b0, snk: 1'b0, lind: 1'b0, ext_prev: 1'b0, oe_n: 1'b1,
    n_val: DIV_000, realign: 1'b0, tol: TOL_RST, thr: THR_RST,
    rdata: '0, rdy: 1'b0, err_bus: 1'b0};

  llp_top_s st_reg;               // state
  llp_top_s st_next;              // next state
  logic     ref_evt;              // delayed sync falling edge
  logic     div_out;              // internal divided clock
  logic     div_rise;             // internal divided rising edge
  logic     fb_evt;               // feedback rising edge, either source
  logic     apb_go;               // access phase to answer now
  logic     cmp_done;             // a phase comparison finished
  logic [CNT_W-1:0] cmp_mag;      // magnitude of that comparison

  // delayed sync reference
  llp_sync_delay #(
    .DLY      (HS_DLY_CYC)
  ) u_dly (
    .core_clk (core_clk),
    .srst     (srst),
    .hsync_in (hsync_in),
    .ref_evt  (ref_evt)
  );

  // internal divide-by-n
  llp_divider u_div (
    .core_clk (core_clk),
    .srst     (srst),
    .n_val    (st_reg.n_val),
    .realign  (st_reg.realign),
    .div_out  (div_out),
    .div_rise (div_rise)
  );

  // feedback edge: internal counter or the external divider pin
  assign fb_evt = st_reg.oe_n ? (ext_div_in & ~st_reg.ext_prev)
                              : div_rise;
  assign apb_go = psel & penable & ~st_reg.rdy;

  // register read mux
  function automatic logic [DATA_W-1:0] rd_mux(input llp_top_s s,
                                               input logic [APB_AW-1:0] a);
    logic [DATA_W-1:0] d;
    d = '0;
    unique case (a)
      REG_CTRL: begin
        d[CTRL_TOL_LSB +: TOL_W] = s.tol;
        d[CTRL_THR_LSB +: THR_W] = s.thr;
      end
      REG_STATUS: begin
        d[ST_LOCKED]       = s.locked;
        d[ST_MODE +: 2]    = s.mode;
        d[ST_INTDIV]       = ~s.oe_n;
        d[ST_SRC]          = s.src;
        d[ST_SNK]          = s.snk;
        d[ST_LIND]         = s.lind;
        d[ST_PEND]         = s.pfd != PFD_IDLE;
      end
      REG_PHASE: d = DATA_W'($signed(s.err));
      REG_DIVN:  d[N_W-1:0] = s.n_val;
      default:   d = '0;
    endcase
    return d;
  endfunction

  // mapped offsets
  function automatic logic mapped(input logic [APB_AW-1:0] a);
    return a == REG_CTRL || a == REG_STATUS || a == REG_PHASE || a == REG_DIVN;
  endfunction

  // next state: pin decode, phase detector, pump, indicator, apb
  always_comb begin
    st_next          = st_reg;
    cmp_done         = 1'b0;
    cmp_mag          = '0;
    st_next.mode     = llp_mode(hold_mode);
    st_next.n_val    = llp_ratio(prog_sel);
    st_next.oe_n     = ~div_sel;
    st_next.ext_prev = ext_div_in;
    st_next.realign  = 1'b0;
    // pending count saturates so a lost edge cannot wrap
    if (st_reg.cnt != '1) begin
      st_next.cnt = st_reg.cnt + CNT_W'(1);
    end
    unique case (st_reg.pfd)
      PFD_IDLE: begin
        st_next.cnt = CNT_W'(1);
        if (ref_evt && fb_evt) begin
          cmp_done = 1'b1;
        end else if (ref_evt) begin
          st_next.pfd = PFD_UP;
        end else if (fb_evt) begin
          st_next.pfd = PFD_DN;
        end
      end
      PFD_UP: begin
        // reference came first: divided clock lags, error positive
        if (fb_evt) begin
          cmp_done    = 1'b1;
          cmp_mag     = st_reg.cnt;
          st_next.err = ERR_W'(st_reg.cnt);
          st_next.pfd = PFD_IDLE;
        end else if (st_reg.mode == LLP_FAST && !st_reg.realign &&
                     st_reg.cnt == CNT_W'(st_reg.thr)) begin
          // one shot per pending compare, so the divider is not held in restart
          st_next.realign = 1'b1;
        end
      end
      PFD_DN: begin
        // divided clock came first: leads, error negative
        if (ref_evt) begin
          st_next.err = ERR_W'(-$signed({4'h0, st_reg.cnt}));
          if (st_reg.mode == LLP_FAST && st_reg.cnt >= CNT_W'(st_reg.thr)) begin
            // restart the divider on this reference edge
            st_next.realign = 1'b1;
            st_next.pfd     = PFD_UP;
            st_next.cnt     = CNT_W'(1);              // measure from this reference
          end else begin
            cmp_done    = 1'b1;
            cmp_mag     = st_reg.cnt;
            st_next.pfd = PFD_IDLE;
          end
        end
      end
      default: st_next.pfd = PFD_IDLE;
    endcase
    // lock judged on each finished comparison
    if (cmp_done) begin
      st_next.locked = cmp_mag < CNT_W'(st_reg.tol);
    end
    // coast: detector held idle, nothing pumped, missing sync ignored
    if (st_next.mode == LLP_COAST) begin
      st_next.pfd     = PFD_IDLE;
      st_next.cnt     = '0;
      st_next.realign = 1'b0;
    end
    // pump follows the detector; one state means one enable only
    st_next.src  = st_next.pfd == PFD_UP;
    st_next.snk  = st_next.pfd == PFD_DN;
    // indicator pulses only for errors beyond tolerance
    st_next.lind = st_next.pfd != PFD_IDLE &&
                   st_next.cnt >= CNT_W'(st_reg.tol);
    // apb: answer one cycle into the access phase
    st_next.rdy     = apb_go;
    st_next.err_bus = apb_go & ~mapped(paddr);
    if (apb_go) begin
      st_next.rdata = pwrite ? '0 : rd_mux(st_reg, paddr);
      if (pwrite && paddr == REG_CTRL) begin
        st_next.tol = pwdata[CTRL_TOL_LSB +: TOL_W];
        st_next.thr = pwdata[CTRL_THR_LSB +: THR_W];
      end
    end
  end

  // single state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= RST_S;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign prdata         = st_reg.rdata;
  assign pready         = st_reg.rdy;
  assign pslverr        = st_reg.err_bus;
  assign ext_div_out    = div_out;
  assign ext_div_oe_n   = st_reg.oe_n;
  assign pump_src       = st_reg.src;
  assign pump_snk       = st_reg.snk;
  assign lock_indicator = st_reg.lind;

  // checks
  localparam int REF_LAT = HS_DLY_CYC + 1;  // sync fall to reference pulse

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_no_both;
    !(pump_src && pump_snk);
  endproperty
  a_no_both: assert property (p_no_both) else $error("source and sink together");

  property p_int_drive;
    div_sel && !srst |=> !ext_div_oe_n;
  endproperty
  a_int_drive: assert property (p_int_drive) else $error("divider pin not driven");

  property p_ext_in;
    !div_sel && !srst |=> ext_div_oe_n;
  endproperty
  a_ext_in: assert property (p_ext_in) else $error("divider pin driven in ext mode");

  property p_coast_hiz;
    (hold_mode != HOLD_NORMAL && hold_mode != HOLD_FAST) && !srst |=> !pump_src && !pump_snk;
  endproperty
  a_coast_hiz: assert property (p_coast_hiz) else $error("pump active in coast");

  sequence s_ref_first;
    st_reg.pfd == PFD_IDLE && ref_evt && !fb_evt && st_next.mode != LLP_COAST;
  endsequence
  property p_src;
    s_ref_first |=> pump_src && !pump_snk;
  endproperty
  a_src: assert property (p_src) else $error("no source on leading sync");

  sequence s_fb_first;
    st_reg.pfd == PFD_IDLE && fb_evt && !ref_evt && st_next.mode != LLP_COAST;
  endsequence
  property p_snk;
    s_fb_first |=> pump_snk && !pump_src;
  endproperty
  a_snk: assert property (p_snk) else $error("no sink on lagging sync");

  property p_ratio;
    !srst |=> st_reg.n_val == llp_ratio($past(prog_sel));
  endproperty
  a_ratio: assert property (p_ratio) else $error("divisor mismatch");

  property p_ref_delay;
    $fell(hsync_in) ##1 (!hsync_in)[*2] |-> ##(REF_LAT-2) ref_evt;
  endproperty
  a_ref_delay: assert property (p_ref_delay) else $error("reference delay wrong");

  property p_lind_cause;
    lock_indicator |-> (pump_src || pump_snk);
  endproperty
  a_lind_cause: assert property (p_lind_cause) else $error("indicator with no error");

  property p_apb;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer timing");
endmodule // llp_top
`default_nettype wire

// >>> llp_pkg.sv
`default_nettype none
package llp_pkg;
  // clock and timing
  localparam int CLK_NS     = 50;                                 // core_clk period
  localparam int HS_DLY_NS  = 110;                                // sync reference delay
  localparam int HS_DLY_CYC = (HS_DLY_NS + CLK_NS - 1) / CLK_NS;  // least time: round up
  localparam int LOCK_NS    = 50;                                 // residual offset bound
  localparam int LOCK_CYC   = (LOCK_NS / CLK_NS < 1) ? 1 : LOCK_NS / CLK_NS;
  // widths
  localparam int N_W    = 11;                                     // divisor width
  localparam int CNT_W  = 12;                                     // phase counter width
  localparam int ERR_W  = 16;                                     // signed phase error
  localparam int APB_AW = 8;                                      // apb address width
  localparam int TOL_W  = 4;                                      // lock tolerance field
  localparam int THR_W  = 8;                                      // fast lock threshold field
  // divisor table
  localparam logic [N_W-1:0] DIV_000 = 11'h353;
  localparam logic [N_W-1:0] DIV_001 = 11'h360;
  localparam logic [N_W-1:0] DIV_010 = 11'h3B0;
  localparam logic [N_W-1:0] DIV_011 = 11'h46F;
  localparam logic [N_W-1:0] DIV_100 = 11'h2AA;
  localparam logic [N_W-1:0] DIV_101 = 11'h35A;
  localparam logic [N_W-1:0] DIV_110 = 11'h30C;
  localparam logic [N_W-1:0] DIV_111 = 11'h38E;
  // hold mode pin codes from the level comparators
  localparam logic [1:0] HOLD_NORMAL = 2'h0;
  localparam logic [1:0] HOLD_FAST   = 2'h1;
  // register map
  localparam logic [APB_AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [APB_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] REG_PHASE  = 8'h08;
  localparam logic [APB_AW-1:0] REG_DIVN   = 8'h0C;
  localparam int CTRL_TOL_LSB = 0;
  localparam int CTRL_THR_LSB = 8;
  localparam logic [TOL_W-1:0] TOL_RST = TOL_W'(LOCK_CYC);
  localparam logic [THR_W-1:0] THR_RST = 8'h10;
  localparam int ST_LOCKED = 0;
  localparam int ST_MODE   = 1;
  localparam int ST_INTDIV = 3;
  localparam int ST_SRC    = 4;
  localparam int ST_SNK    = 5;
  localparam int ST_LIND   = 6;
  localparam int ST_PEND   = 7;
  localparam int DATA_W    = 32;

  typedef enum logic [1:0] {LLP_NORMAL, LLP_FAST, LLP_COAST} llp_mode_e;
  typedef enum logic [1:0] {PFD_IDLE, PFD_UP, PFD_DN} llp_pfd_e;

  // ratio select to divisor, first select bit most significant
  function automatic logic [N_W-1:0] llp_ratio(input logic [2:0] sel);
    logic [N_W-1:0] n;
    unique case (sel)
      3'h0: n = DIV_000;
      3'h1: n = DIV_001;
      3'h2: n = DIV_010;
      3'h3: n = DIV_011;
      3'h4: n = DIV_100;
      3'h5: n = DIV_101;
      3'h6: n = DIV_110;
      3'h7: n = DIV_111;
    endcase
    return n;
  endfunction

  // comparator code to mode; the unused code falls safe into coast
  function automatic llp_mode_e llp_mode(input logic [1:0] code);
    llp_mode_e m;
    if (code == HOLD_NORMAL) m = LLP_NORMAL;
    else if (code == HOLD_FAST) m = LLP_FAST;
    else m = LLP_COAST;
    return m;
  endfunction
endpackage
`default_nettype wire

// >>> llp_sync_delay.sv
`timescale 1ns/1ns
`default_nettype none
// delays horizontal sync and marks its falling edge as the reference event
module llp_sync_delay
  import llp_pkg::*;
#(
  parameter int DLY = HS_DLY_CYC  // delay stages in core_clk cycles
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // sync in, reference pulse out
  input  wire logic hsync_in,
  output logic      ref_evt
);
  typedef struct packed {
    logic [DLY:0] line;  // delay line, bit 0 newest
    logic         evt;   // one-cycle reference pulse
  } llp_dly_s;

  llp_dly_s st_reg;      // state
  llp_dly_s st_next;     // next state

  // shift the sync and look for the falling edge at the tap
  always_comb begin
    st_next      = st_reg;
    st_next.line = {st_reg.line[DLY-1:0], hsync_in};
    st_next.evt  = st_reg.line[DLY] & ~st_reg.line[DLY-1];
  end

  // state register; line resets high so no false edge at start
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '{line: '1, evt: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign ref_evt = st_reg.evt;
endmodule // llp_sync_delay
`default_nettype wire

// >>> llp_divider.sv
`timescale 1ns/1ns
`default_nettype none
// programmable divide-by-n of the output clock with realign
module llp_divider
  import llp_pkg::*;
(
  // clock and reset
  input  wire logic           core_clk,
  input  wire logic           srst,
  // control
  input  wire logic [N_W-1:0] n_val,
  input  wire logic           realign,
  // divided clock and its rising-edge pulse
  output logic                div_out,
  output logic                div_rise
);
  typedef struct packed {
    logic [N_W-1:0] cnt;   // position within the period
    logic           out;   // divided clock, high in first half
    logic           rise;  // pulse on rising edge
  } llp_div_s;

  llp_div_s st_reg;        // state
  llp_div_s st_next;       // next state

  // count through n states; realign forces a fresh rising edge
  always_comb begin
    st_next = st_reg;
    if (realign) begin
      // park at the period end: the next edge is a true rise on the pin
      st_next.cnt = n_val - N_W'(1);
    end else if (st_reg.cnt >= n_val - N_W'(1)) begin
      st_next.cnt = '0;
    end else begin
      st_next.cnt = st_reg.cnt + N_W'(1);
    end
    st_next.out  = st_next.cnt < (n_val >> 1);
    st_next.rise = st_next.out & ~st_reg.out;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign div_out  = st_reg.out;
  assign div_rise = st_reg.rise;
endmodule // llp_divider
`default_nettype wire

// >>> llp_far_model.sv
`timescale 1ns/1ns
`default_nettype none
// far side: sync source plus an external divider on the divider pin
module llp_far_model
  import llp_pkg::*;
(
  // clock
  input  wire logic              core_clk,
  // command from the bench
  input  wire logic              trig,
  input  wire logic signed [7:0] lag,
  // sync and divider pin drive
  output logic                   hsync_in,
  output logic                   ext_drv
);
  logic [5:0] cnt_reg;  // cycles since sync fell
  logic       busy_reg; // one line in flight
  initial begin
    hsync_in = 1'h1;
    ext_drv  = 1'h0;
    cnt_reg  = 6'h00;
    busy_reg = 1'h0;
  end
  // sync falls on command; divider edge lands lag cycles after the delayed fall
  always @(posedge core_clk) begin
    if (trig) begin
      busy_reg <= 1'h1;
      cnt_reg  <= 6'h00;
      hsync_in <= 1'h0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg + 6'h01;
      // sync low for nine cycles, then idle high
      if (cnt_reg == 6'h08) begin
        hsync_in <= 1'h1;
      end
      // external divider supplies the divided clock
      if (int'(cnt_reg) == 3 + int'(lag)) begin
        ext_drv <= 1'h1;
      end
      if (int'(cnt_reg) == 11 + int'(lag)) begin
        ext_drv <= 1'h0;
      end
      // line over; lag must stay within -3..29
      if (cnt_reg == 6'h28) begin
        busy_reg <= 1'h0;
      end
    end
  end
endmodule // llp_far_model
`default_nettype wire

// >>> test_line_locked_pll_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_line_locked_pll_control
  import llp_pkg::*;
;
  logic              core_clk, srst, psel, penable, pwrite;
  logic [APB_AW-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic              pready, pslverr, hsync_in, div_sel;
  logic [2:0]        prog_sel;
  logic [1:0]        hold_mode;
  logic              ext_wire, ext_div_out, ext_div_oe_n, ext_drv;
  logic              pump_src, pump_snk, lock_indicator, trig;
  logic signed [7:0] trig_lag;
  logic              s_src, s_snk, s_li, s_both, s_rise; // seen during a line
  int                fails, cmp_count;
  // divisors 851 864 944 1135 682 858 780 910
  logic [31:0] ntab [8] = '{32'h353, 32'h360, 32'h3B0, 32'h46F,
                            32'h2AA, 32'h35A, 32'h30C, 32'h38E};
  // divider pin: device wins while its enable is low
  assign ext_wire = (ext_div_oe_n === 1'h0) ? ext_div_out : ext_drv;
  llp_top dut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hsync_in(hsync_in), .div_sel(div_sel), .prog_sel(prog_sel),
    .hold_mode(hold_mode), .ext_div_in(ext_wire), .ext_div_out(ext_div_out),
    .ext_div_oe_n(ext_div_oe_n), .pump_src(pump_src), .pump_snk(pump_snk),
    .lock_indicator(lock_indicator));
  llp_far_model far (.core_clk(core_clk), .trig(trig), .lag(trig_lag),
    .hsync_in(hsync_in), .ext_drv(ext_drv));
  // 20 mhz clock
  always #25 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; idle edge after it avoids a double drive
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    d = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 50) fails++;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'h0, a, 32'h0, d, e);
  endtask
  // cycles to the next divided-clock rise, bounded
  task automatic wait_rise(output int n);
    logic p;
    n = 0;
    p = ext_div_out;
    do begin
      @(posedge core_clk);
      n++;
      if (ext_div_out === 1'h1 && p === 1'h0) break;
      p = ext_div_out;
    end while (n < 4200);
    if (n >= 4200) fails++;
  endtask
  // one sync line from the far side, watching pump and indicator
  task automatic run_evt(input logic signed [7:0] lg);
    logic p;
    trig_lag <= lg;
    trig <= 1'h1;
    @(posedge core_clk);
    trig <= 1'h0;
    {s_src, s_snk, s_li, s_both, s_rise} = 5'h00;
    p = ext_div_out;
    repeat (45) begin
      @(posedge core_clk);
      s_src |= pump_src;
      s_snk |= pump_snk;
      s_li |= lock_indicator;
      s_both |= pump_src & pump_snk;
      s_rise |= ext_div_out & ~p;
      p = ext_div_out;
    end
    chk("pump_both", 32'(s_both), 32'h0);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic e;
    rd(REG_CTRL, d);
    chk("ctrl_rst", d, 32'h00001001);
    apb(1'h0, 8'h10, 32'h0, d, e);
    chk("unmapped_err", 32'(e), 32'h1);
    chk("unmapped_data", d, 32'h0);
    apb(1'h1, REG_DIVN, 32'h0, d, e);
    rd(REG_DIVN, d);
    chk("divn_ro", d, ntab[0]);
  endtask
  // every ratio code: register value and true period at the pin
  task automatic t_divide();
    logic [31:0] d;
    int n;
    for (int s = 0; s < 8; s++) begin
      prog_sel <= 3'(s);
      rd(REG_DIVN, d);
      chk("divn", d, ntab[s]);
      wait_rise(n);
      wait_rise(n);
      chk("div_period", 32'(n), ntab[s]);
    end
    chk("oe_n_int", 32'(ext_div_oe_n), 32'h0);
  endtask
  // external divider: lag, lead, exact and one-off alignment
  task automatic t_ext();
    logic [31:0] d;
    div_sel <= 1'h0;
    hold_mode <= 2'h2;  // coast drops the compare left pending by the divide test
    repeat (3) @(posedge core_clk);
    chk("oe_n_ext", 32'(ext_div_oe_n), 32'h1);
    hold_mode <= 2'h0;
    repeat (2) @(posedge core_clk);
    run_evt(8'sh03);
    chk("src_lag", 32'(s_src), 32'h1);
    chk("snk_lag", 32'(s_snk), 32'h0);
    chk("ind_lag", 32'(s_li), 32'h1);
    rd(REG_PHASE, d);
    chk("phase_pos", d, 32'h3);
    rd(REG_STATUS, d);
    chk("int_div_off", {31'h0, d[3]}, 32'h0);
    run_evt(-8'sh03);
    chk("snk_lead", 32'(s_snk), 32'h1);
    chk("src_lead", 32'(s_src), 32'h0);
    rd(REG_PHASE, d);
    chk("phase_neg", d, 32'hFFFFFFFD);
    run_evt(8'sh00);
    chk("pump_lock", 32'({s_src, s_snk}), 32'h0);
    chk("ind_lock", 32'(s_li), 32'h0);
    rd(REG_STATUS, d);
    chk("locked", {31'h0, d[0]}, 32'h1);
    run_evt(8'sh01);
    rd(REG_STATUS, d);
    chk("unlocked_1", {31'h0, d[0]}, 32'h0);
  endtask
  // wider tolerance: small error still pumps, indicator stays low
  task automatic t_tol();
    logic [31:0] d;
    logic e;
    apb(1'h1, REG_CTRL, 32'h00001004, d, e);
    rd(REG_CTRL, d);
    chk("ctrl_wr", d, 32'h00001004);
    run_evt(8'sh02);
    chk("src_small", 32'(s_src), 32'h1);
    chk("ind_small", 32'(s_li), 32'h0);
  endtask
  task automatic t_coast();
    logic [31:0] d;
    hold_mode <= 2'h2;
    repeat (3) @(posedge core_clk);
    rd(REG_STATUS, d);
    chk("mode_coast", {30'h0, d[2:1]}, 32'h2);
    run_evt(8'sh05);
    chk("coast_quiet", 32'({s_src, s_snk, s_li}), 32'h0);
    rd(REG_PHASE, d);
    chk("coast_phase", d, 32'h2);
  endtask
  // fast lock: sync far from the divider edge forces a realign
  task automatic t_fast();
    logic [31:0] d;
    int n;
    hold_mode <= 2'h1;
    div_sel <= 1'h1;
    prog_sel <= 3'h7;
    repeat (3) @(posedge core_clk);
    rd(REG_STATUS, d);
    chk("mode_fast", {30'h0, d[2:1]}, 32'h1);
    wait_rise(n);
    repeat (200) @(posedge core_clk);
    run_evt(8'sh04);
    chk("realign", 32'(s_rise), 32'h1);
  endtask
  task automatic test_done();
    $display("mismatches %0d of %0d checks", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {core_clk, psel, penable, pwrite, trig} = 5'h00;
    {paddr, pwdata, trig_lag} = '0;
    {srst, div_sel} = 2'h3;
    prog_sel = 3'h0;
    hold_mode = 2'h0;
    fails = 0;
    cmp_count = 0;
    repeat (20) @(posedge core_clk);
    chk("rst_outs", 32'({pready, pump_src, pump_snk, lock_indicator, ext_div_out}), 32'h0);
    chk("rst_oe_n", 32'(ext_div_oe_n), 32'h1);
    srst <= 1'h0;
    @(posedge core_clk);
    t_regs();
    t_divide();
    t_ext();
    t_tol();
    t_coast();
    t_fast();
    test_done();
  end
  // hang guard
  initial begin
    repeat (40000) @(posedge core_clk);
    fails++;
    test_done();
  end
endmodule // test_line_locked_pll_control
`default_nettype wire
